// *** osc_mode_pll_select.v ***
// Oscillator mode decode, aux pin routing and times-four clock multiplier control.
// Assumes the configuration field is stable while reset is held and that the
// oscillator input runs at most one eighth of the system clock.
//
// Added by the designer: register access over Wishbone and the register addresses.
`include "osc_pll_defs.vh"

module osc_mode_pll_select #(
  parameter LOCK_CYCLES = `LOCK_CYCLES,
  parameter PERIOD_W = 16
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Configuration and system events
  input wire [`CFG_W-1:0] oscillator_config_field_i,
  input wire wake_i,
  input wire sec_osc_active_i,
  // Oscillator pins
  input wire clock_input_pin_i,
  input wire clock_aux_pin_i,
  output reg clock_aux_pin_o,
  output reg clock_aux_pin_oe_o,
  output reg feedback_amp_en_o,
  // Port A bit six general purpose side
  input wire port_a_bit_six_out_i,
  input wire port_a_bit_six_oe_i,
  output wire port_a_bit_six_in_o,
  // Core clock tree
  output reg core_clk_en_o,
  output wire core_run_o,
  output wire mult_active_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decoding

  function [`FL_W-1:0] mode_flags;
    input [`CFG_W-1:0] cfg;
    begin
      mode_flags = {`FL_W{1'b0}};
      case (cfg)
        `MODE_LP, `MODE_XT, `MODE_HS: begin
          mode_flags[`FL_XTAL] = 1'b1;
        end
        `MODE_HS_FIXED: begin
          mode_flags[`FL_XTAL] = 1'b1;
          mode_flags[`FL_FIXED] = 1'b1;
        end
        `MODE_HS_SOFT: begin
          mode_flags[`FL_XTAL] = 1'b1;
          mode_flags[`FL_SOFT] = 1'b1;
        end
        `MODE_EC: begin
          mode_flags[`FL_EXT] = 1'b1;
          mode_flags[`FL_DIV4] = 1'b1;
        end
        `MODE_EXT_CLOCK_GPIO_MODE: begin
          mode_flags[`FL_EXT] = 1'b1;
          mode_flags[`FL_GPIO] = 1'b1;
        end
        `MODE_EXT_CLOCK_GPIO_MODE_FIXED: begin
          mode_flags[`FL_EXT] = 1'b1;
          mode_flags[`FL_GPIO] = 1'b1;
          mode_flags[`FL_FIXED] = 1'b1;
        end
        `MODE_EXT_CLOCK_GPIO_MODE_SOFT: begin
          mode_flags[`FL_EXT] = 1'b1;
          mode_flags[`FL_GPIO] = 1'b1;
          mode_flags[`FL_SOFT] = 1'b1;
        end
        `MODE_RESISTOR_CAP_GPIO_MODE, `MODE_RESISTOR_CAP_GPIO_MODE_ALT: begin
          mode_flags[`FL_RC] = 1'b1;
          mode_flags[`FL_GPIO] = 1'b1;
        end
        default: begin
          // Unassigned codes fall back to the plain resistor-cap mode
          mode_flags[`FL_RC] = 1'b1;
          mode_flags[`FL_DIV4] = 1'b1;
        end
      endcase
    end
  endfunction

  reg [`CFG_W-1:0] cfg_reg;
  wire [`FL_W-1:0] flags;

  // Field is caught while reset is held and stays fixed afterwards
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= oscillator_config_field_i;
    end
  end

  assign flags = mode_flags(cfg_reg);

  wire is_ext = flags[`FL_EXT];
  wire is_div4 = flags[`FL_DIV4];
  wire is_gpio = flags[`FL_GPIO];
  wire is_fixed = flags[`FL_FIXED];
  wire is_soft = flags[`FL_SOFT];

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  wire osc_rise;
  wire osc_div4;

  // Same input pin path for crystal, resonator or driven clock
  pin_edge_div4 u_osc_pin (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(clock_input_pin_i),
    .rise_o(osc_rise),
    .div4_o(osc_div4)
  );

  reg aux_sync1_reg;
  reg aux_sync2_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      aux_sync1_reg <= 1'b0;
      aux_sync2_reg <= 1'b0;
    end else begin
      aux_sync1_reg <= clock_aux_pin_i;
      aux_sync2_reg <= aux_sync1_reg;
    end
  end

  // Port bit reads the pin only when the pin is handed to it
  assign port_a_bit_six_in_o = is_gpio & aux_sync2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Aux pin and feedback amplifier

  always @(posedge clk_i) begin
    if (rst_i) begin
      clock_aux_pin_o <= 1'b0;
      clock_aux_pin_oe_o <= 1'b0;
      feedback_amp_en_o <= 1'b0;
    end else begin
      // Amplifier only serves a crystal; off for every external or RC mode
      feedback_amp_en_o <= flags[`FL_XTAL];
      if (is_gpio) begin
        clock_aux_pin_o <= port_a_bit_six_out_i;
        clock_aux_pin_oe_o <= port_a_bit_six_oe_i;
      end else if (is_div4) begin
        clock_aux_pin_o <= osc_div4;
        clock_aux_pin_oe_o <= 1'b1;
      end else begin
        clock_aux_pin_o <= 1'b0;
        clock_aux_pin_oe_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External-clock start-up interval

  localparam integer STARTUP_FULL = `STARTUP_CYCLES;
  localparam [5:0] STARTUP_LOAD = STARTUP_FULL[5:0];
  reg [5:0] startup_reg;
  reg startup_armed_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      startup_reg <= 6'h00;
      startup_armed_reg <= 1'b1;
    end else if (startup_armed_reg || wake_i) begin
      startup_armed_reg <= 1'b0;
      // Reset arming already costs one cycle, so it loads one less
      startup_reg <= !is_ext ? 6'h00 : startup_armed_reg ? STARTUP_LOAD - 6'h01 : STARTUP_LOAD;
    end else if (startup_reg != 6'h00) begin
      startup_reg <= startup_reg - 6'h01;
    end
  end

  wire startup_busy = startup_armed_reg | (startup_reg != 6'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Multiplier enable and lock

  reg mult_en_reg;
  reg use_mult_reg;
  reg mult_req_last_reg;
  wire mult_en_bit;
  wire mult_req;
  wire lock_busy;
  wire lock_done;
  wire locked;

  // Forced set, writable or forced clear depending on mode
  assign mult_en_bit = is_fixed | (is_soft & mult_en_reg);
  // Secondary oscillator in use stops the multiplier; returning relocks it
  assign mult_req = mult_en_bit & ~sec_osc_active_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      mult_req_last_reg <= 1'b0;
    end else begin
      mult_req_last_reg <= mult_req;
    end
  end

  lock_timer #(
    .WIDTH(32),
    .CYCLES(LOCK_CYCLES)
  ) u_lock (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(mult_req & ~mult_req_last_reg),
    .clear_i(~mult_req & mult_req_last_reg),
    .busy_o(lock_busy),
    .done_o(lock_done)
  );

  assign locked = lock_done & mult_req;
  // Fixed modes run from the multiplier whenever it is locked; soft modes also need the select
  assign mult_active_o = locked & (is_fixed | use_mult_reg);
  // Core waits out start-up and any pending lock
  assign core_run_o = ~startup_busy & ~(mult_req & ~locked);

  ////////////////////////////////////////////////////////////////////////////
  // Core clock enable generation

  reg [PERIOD_W-1:0] period_cnt_reg;
  reg [PERIOD_W-1:0] period_reg;
  reg [PERIOD_W-1:0] phase_reg;
  reg [1:0] quarter_reg;
  wire [PERIOD_W-1:0] quarter_len = {2'b00, period_reg[PERIOD_W-1:2]};

  always @(posedge clk_i) begin
    if (rst_i) begin
      period_cnt_reg <= {PERIOD_W{1'b0}};
      period_reg <= {PERIOD_W{1'b0}};
      phase_reg <= {PERIOD_W{1'b0}};
      quarter_reg <= 2'h0;
      core_clk_en_o <= 1'b0;
    end else begin
      core_clk_en_o <= 1'b0;
      if (osc_rise) begin
        period_reg <= period_cnt_reg + {{(PERIOD_W-1){1'b0}}, 1'b1};
        period_cnt_reg <= {PERIOD_W{1'b0}};
        phase_reg <= {PERIOD_W{1'b0}};
        quarter_reg <= 2'h0;
        core_clk_en_o <= core_run_o;
      end else begin
        if (period_cnt_reg != {PERIOD_W{1'b1}}) begin
          period_cnt_reg <= period_cnt_reg + {{(PERIOD_W-1){1'b0}}, 1'b1};
        end
        phase_reg <= phase_reg + {{(PERIOD_W-1){1'b0}}, 1'b1};
        // Three extra evenly spaced ticks per input period when multiplying
        if (mult_active_o && quarter_reg != 2'h3 && quarter_len != {PERIOD_W{1'b0}} &&
            phase_reg + {{(PERIOD_W-1){1'b0}}, 1'b1} == quarter_len) begin
          phase_reg <= {PERIOD_W{1'b0}};
          quarter_reg <= quarter_reg + 2'h1;
          core_clk_en_o <= core_run_o;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone register access

  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire wr_ctrl = bus_req & we_i & sel_i[0] & ({adr_i[3:2], 2'b00} == `ADDR_CTRL);

  always @(posedge clk_i) begin
    if (rst_i) begin
      mult_en_reg <= 1'b0;
      use_mult_reg <= 1'b0;
    end else begin
      if (wr_ctrl && is_soft) begin
        mult_en_reg <= dat_i[`CTRL_MULT_EN];
      end
      if (wr_ctrl) begin
        use_mult_reg <= dat_i[`CTRL_USE_MULT];
      end
      // Select bit cannot stay set without an enabled, locked multiplier
      if (!(is_soft && mult_en_reg && lock_done)) begin
        if (!(wr_ctrl && is_soft && dat_i[`CTRL_MULT_EN] && dat_i[`CTRL_USE_MULT])) begin
          use_mult_reg <= 1'b0;
        end
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      dat_o <= 32'h0000_0000;
      if (bus_req && !we_i) begin
        case ({adr_i[3:2], 2'b00})
          `ADDR_CTRL: begin
            dat_o[`CTRL_USE_MULT] <= use_mult_reg & locked;
            dat_o[`CTRL_MULT_EN] <= mult_en_bit;
            dat_o[`CTRL_LOCK] <= locked;
          end
          `ADDR_STATUS: begin
            dat_o[`ST_CFG_LSB+`CFG_W-1:`ST_CFG_LSB] <= cfg_reg;
            dat_o[`ST_RUN] <= core_run_o;
            dat_o[`ST_MULT_ACT] <= mult_active_o;
            dat_o[`ST_FEEDBACK] <= feedback_amp_en_o;
            dat_o[`ST_AUX_GPIO] <= is_gpio;
          end
          default: begin
            dat_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Lock busy is visible to the core only through core_run_o
  wire unused_busy = lock_busy;

endmodule

// *** osc_pll_defs.vh ***
// Constants for the oscillator mode and clock multiplier control block.
// Assumes a 20 MHz system clock and classic Wishbone register access.
`ifndef OSC_PLL_DEFS_VH
`define OSC_PLL_DEFS_VH

// Oscillator configuration field encoding
`define CFG_W 4
`define MODE_LP 4'h0
`define MODE_XT 4'h1
`define MODE_HS 4'h2
`define MODE_RC 4'h3
`define MODE_EC 4'h4
`define MODE_EXT_CLOCK_GPIO_MODE 4'h5
`define MODE_HS_FIXED 4'h6
`define MODE_RESISTOR_CAP_GPIO_MODE 4'h7
`define MODE_EXT_CLOCK_GPIO_MODE_SOFT 4'h8
`define MODE_EXT_CLOCK_GPIO_MODE_FIXED 4'h9
`define MODE_HS_SOFT 4'ha
`define MODE_RESISTOR_CAP_GPIO_MODE_ALT 4'hb

// Decoded mode flag positions
`define FL_EXT 0
`define FL_RC 1
`define FL_XTAL 2
`define FL_DIV4 3
`define FL_GPIO 4
`define FL_FIXED 5
`define FL_SOFT 6
`define FL_W 7

// Register byte addresses
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4

// Control register bits
`define CTRL_USE_MULT 1
`define CTRL_MULT_EN 2
`define CTRL_LOCK 3

// Status register fields
`define ST_CFG_LSB 0
`define ST_RUN 4
`define ST_MULT_ACT 5
`define ST_FEEDBACK 6
`define ST_AUX_GPIO 7

// Timing
`define CLK_PERIOD_NS 50
`define STARTUP_NS 1500
`define LOCK_TIMEOUT_NS 2000000
`define STARTUP_CYCLES (`STARTUP_NS / `CLK_PERIOD_NS)
`define LOCK_CYCLES (`LOCK_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

// *** pin_edge_div4.v ***
// Synchroniser, rising-edge detector and divide-by-four for an oscillator pin.
// Assumes the pin toggles well below half the system clock rate.
`include "osc_pll_defs.vh"

module pin_edge_div4 (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Pin and results
  input wire pin_i,
  output wire rise_o,
  output wire div4_o
);

  reg sync1_reg;
  reg sync2_reg;
  reg last_reg;
  reg [1:0] div_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg <= 1'b0;
      div_reg <= 2'h0;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
      if (rise_o) begin
        div_reg <= div_reg + 2'h1;
      end
    end
  end

  assign rise_o = sync2_reg & ~last_reg;
  // Top bit of a two-bit edge counter: one period per four input periods
  assign div4_o = div_reg[1];

endmodule

// *** lock_timer.v ***
// Down-counting lock timer with start and abort.
// Assumes start and clear are single-cycle pulses on the system clock.
`include "osc_pll_defs.vh"

module lock_timer #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] CYCLES = 16'h0010
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Control
  input wire start_i,
  input wire clear_i,
  // Status
  output wire busy_o,
  output reg done_o
);

  reg [WIDTH-1:0] cnt_reg;

  always @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      cnt_reg <= {WIDTH{1'b0}};
      done_o <= 1'b0;
    end else if (start_i) begin
      cnt_reg <= CYCLES;
      done_o <= 1'b0;
    end else if (cnt_reg != {WIDTH{1'b0}}) begin
      cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      if (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1}) begin
        done_o <= 1'b1;
      end
    end
  end

  assign busy_o = cnt_reg != {WIDTH{1'b0}};

endmodule

// *** ext_osc_model.sv ***
// External clock source model for the oscillator input pin.
// Assumes nothing of the block; runs free while run_i is high.
module ext_osc_model #(
  parameter int HALF_NS = 400
) (
  // Control
  input wire logic run_i,
  input wire logic slow_i,
  // Pin
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // One source serves the external and the crystal modes alike
  initial pin_o = 1'b0;
  always begin
    #(slow_i ? 2 * HALF_NS : HALF_NS);
    pin_o = run_i ? ~pin_o : 1'b0;
  end
endmodule

// *** osc_mode_monitor.sv ***
// Port checker for the oscillator mode block.
// Assumes the mode code is held steady once reset is released.
module osc_mode_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  // Mode and clock tree
  input wire logic [3:0] oscillator_config_field_i,
  input wire logic feedback_amp_en_o,
  input wire logic clock_aux_pin_oe_o,
  input wire logic port_a_bit_six_in_o,
  input wire logic core_run_o,
  input wire logic mult_active_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] XT_M = 16'h0447;
  localparam logic [15:0] GP_M = 16'h0ba0;
  localparam logic [15:0] ML_M = 16'h0540;
  wire [3:0] m = oscillator_config_field_i;
  wire xt = XT_M[m];
  wire gp = GP_M[m];
  logic [1:0] up_reg;
  ////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (rst_i)
      up_reg <= 2'h0;
    else if (up_reg != 2'h3)
      up_reg <= up_reg + 2'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0000_0000) else $error("read data outside ack");
  fb_off_a: assert property (!xt |-> !feedback_amp_en_o) else $error("feedback on in external mode");
  fb_on_a: assert property (xt && up_reg == 2'h3 |-> feedback_amp_en_o) else $error("feedback off");
  aux_div_a: assert property (!xt && !gp && up_reg == 2'h3 |-> clock_aux_pin_oe_o)
    else $error("aux pin not driven");
  gpio_zero_a: assert property (!gp |-> !port_a_bit_six_in_o) else $error("port bit live");
  mult_only_a: assert property (!ML_M[m] && m != 4'h9 |-> !mult_active_o) else $error("x4 in bad mode");
  ext_start_a: assert property ($fell(rst_i) && (m == 4'h4 || m == 4'h5) |-> ##[1:30] core_run_o)
    else $error("start-up too long");
  lock_hold_a: assert property ($fell(rst_i) && (m == 4'h6 || m == 4'h9) |-> !core_run_o [*8])
    else $error("ran before lock");
  soft_reset_a: assert property ($fell(rst_i) && (m == 4'h8 || m == 4'ha) |-> !mult_active_o [*8])
    else $error("soft mode starts at x4");
  cover property ($rose(mult_active_o));
  cover property (gp && port_a_bit_six_in_o);
  cover property ($rose(core_run_o) && m == 4'h4);
endmodule

bind osc_mode_pll_select osc_mode_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .dat_o(dat_o), .oscillator_config_field_i(oscillator_config_field_i),
  .feedback_amp_en_o(feedback_amp_en_o), .clock_aux_pin_oe_o(clock_aux_pin_oe_o),
  .port_a_bit_six_in_o(port_a_bit_six_in_o), .core_run_o(core_run_o), .mult_active_o(mult_active_o));

// *** testbench.sv ***
// Self-checking bench for the oscillator mode and multiplier block.
// Assumes the clock source model and the port checker are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOCK = 50;
  localparam int START = 30;
  localparam logic [15:0] XT_M = 16'h0447, GP_M = 16'h0ba0, FX_M = 16'h0240, SF_M = 16'h0500;
  localparam logic [15:0] EC_M = 16'h0130;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, wake_i = 0, sec_i = 0;
  logic pa_out = 0, pa_oe = 0, ext_lvl = 0, slow = 0, r, xt, gp, fx, sf;
  logic [3:0] adr_i = 4'h0, cfg = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000, rd, seed = 32'h0000_37f9;
  wire [31:0] dat_o;
  wire ack_o, osc_pin, aux_o, aux_oe, fb, pa_in, clk_en, core_run, mult;
  wire aux_wire = aux_oe ? aux_o : ext_lvl;
  int miscompares = 0, n_checks = 0, n, d, ce, at;
  always #25 clk_i = ~clk_i;
  osc_mode_pll_select #(.LOCK_CYCLES(LOCK)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .oscillator_config_field_i(cfg), .wake_i(wake_i), .sec_osc_active_i(sec_i), .clock_input_pin_i(osc_pin),
    .clock_aux_pin_i(aux_wire), .clock_aux_pin_o(aux_o), .clock_aux_pin_oe_o(aux_oe), .feedback_amp_en_o(fb),
    .port_a_bit_six_out_i(pa_out), .port_a_bit_six_oe_i(pa_oe), .port_a_bit_six_in_o(pa_in),
    .core_clk_en_o(clk_en), .core_run_o(core_run), .mult_active_o(mult));
  ext_osc_model u_osc (.run_i(1'b1), .slow_i(slow), .pin_o(osc_pin));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input int got, input int exp, input int tol);
    n_checks++;
    if (got < exp - tol || got > exp + tol) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] dv);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, dv};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      miscompares++;
      summarize();
    end
    rd = dat_o;
    {cyc_i, stb_i} <= 2'h0;
  endtask
  task automatic wait_run(output int k);
    k = 0;
    while (core_run !== 1'b1 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 400) begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic count_ticks();
    logic p;
    {ce, at} = 0;
    repeat (64) @(posedge clk_i);
    p = aux_o;
    repeat (128) begin
      @(posedge clk_i);
      ce += (clk_en === 1'b1);
      at += (aux_o !== p);
      p = aux_o;
    end
  endtask
  initial begin
    for (int m = 0; m < 16; m++) begin
      {xt, gp, fx, sf} = {XT_M[m], GP_M[m], FX_M[m], SF_M[m]};
      @(posedge clk_i);
      {rst_i, cfg, slow} <= {1'b1, m[3:0], m[0]};
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_run(d);
      if (EC_M[m]) chk_near(d, START, 1);
      if (fx) chk(d >= LOCK, 1);
      wb(0, 4'h4, 32'h0000_0000);
      chk(rd, {24'h00_0000, gp, xt, fx, 1'b1, m[3:0]});
      chk(fb, xt);
      wb(0, 4'h0, 32'h0000_0000);
      chk(rd & 32'h0000_0006, {29'h0, fx, 2'h0});
      wb(0, 4'h8, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      if (!sf) begin
        seed = lfsr(seed);
        wb(1, 4'h0, seed);
        wb(0, 4'h0, 32'h0000_0000);
        chk(rd & 32'h0000_0006, {29'h0, fx, 2'h0});
        chk(mult, fx);
      end else begin
        chk(mult, 1'b0);
        wb(1, 4'h0, 32'h0000_0004);
        chk(core_run, 1'b0);
        d = 0;
        do begin
          wb(0, 4'h0, 32'h0000_0000);
          d++;
        end while (rd[3] !== 1'b1 && d < 60);
        chk(rd[3], 1'b1);
        wb(1, 4'h0, 32'h0000_0006);
        repeat (2) @(posedge clk_i);
        chk({core_run, mult}, 2'h3);
      end
      count_ticks();
      chk_near(ce, ((fx | sf) ? 4 : 1) * (slow ? 4 : 8), (fx | sf) ? 5 : 2);
      chk_near(at, (xt | gp) ? 0 : (slow ? 2 : 4), 1);
      if (gp) begin
        seed = lfsr(seed);
        r = seed[0];
        {pa_oe, pa_out} <= {1'b1, r};
        repeat (4) @(posedge clk_i);
        chk({aux_oe, pa_in}, {1'b1, r});
        {pa_oe, ext_lvl} <= {1'b0, ~r};
        repeat (4) @(posedge clk_i);
        chk({aux_oe, pa_in}, {1'b0, ~r});
      end
      if (m == 6) begin
        sec_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(mult, 1'b0);
        sec_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(core_run, 1'b0);
        wait_run(d);
        chk(mult, 1'b1);
      end
      if (m == 4) begin
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(core_run, 1'b0);
        wait_run(d);
        chk_near(d, START - 2, 1);
      end
    end
    summarize();
  end
endmodule
